// file: rtl/eeprom_map.svh
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_ADDR 8'h04
`define OFF_DATA 8'h08
// ----------------------------------------
// control register fields
// ----------------------------------------
`define B_BUSY 7
`define B_PAGE 6
`define B_MODE_HI 5
`define B_MODE_LO 4
`define B_RIE 3
`define B_MWE 2
`define B_WS 1
`define B_RS 0
// ----------------------------------------
// values and timing counts
// ----------------------------------------
`define ERASED 8'hFF
`define NVM_DEPTH 512
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define MWE_WINDOW 3'h4
`define STALL_READ 3'h4
`define STALL_LOAD 3'h3
`define STALL_WRITE 3'h2
// oscillator ticks per operation: 26368 and 13184
`define TICKS_ATOMIC 32'h00006700
`define TICKS_SPLIT 32'h00003380
`endif

// file: rtl/eeprom_page_access.sv
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module eeprom_page_access
  import eeprom_pkg::*;
#(
  parameter int ATOMIC_TICKS = `TICKS_ATOMIC,
  parameter int SPLIT_TICKS = `TICKS_SPLIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rc_tick,
  output logic cpu_halt,
  output logic ready_irq
);
  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  ctrl_state_t s;
  ctrl_state_t next_s;
  nvm_if bus();
  logic [7:0] wd;
  logic wr_fire;
  logic ctrl_wr;
  logic ws_fire;
  logic rd_fire;
  logic data_fire;
  logic mwe_pending;

  function automatic logic [14:0] ticks_for(prog_mode_t m);
    ticks_for = (m == MODE_ATOMIC) ? ATOMIC_TICKS[14:0] : SPLIT_TICKS[14:0];
  endfunction : ticks_for

  assign wd = s.w_data[7:0];
  assign mwe_pending = (s.mwe_count != 3'h0);
  assign wr_fire = (s.wst == WR_IDLE) && s.aw_got && s.w_got;
  assign ctrl_wr = wr_fire && (s.aw_addr == `OFF_CTRL) && s.w_strb[0];
  // strobe without a live master enable does nothing
  assign ws_fire = ctrl_wr && wd[`B_WS] && mwe_pending && !s.write_strobe;
  assign rd_fire = ctrl_wr && wd[`B_RS] && !s.memory_busy_flag;
  assign data_fire = wr_fire && (s.aw_addr == `OFF_DATA) && s.w_strb[0] && !s.memory_busy_flag;

  page_buffer u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(bus.pbuf)
  );

  nvm_array u_mem (
    .aclk(aclk),
    .bus(bus.mem)
  );

  // ----------------------------------------
  // array and buffer feeds
  // ----------------------------------------
  assign bus.rd_addr = s.nvm_address_reg;
  assign bus.load_idx = s.nvm_address_reg[1:0];
  assign bus.load_data = wd;
  assign bus.prog_page = s.nvm_address_reg[8:2];
  assign bus.prog_mask = s.page_op ? bus.filled : (4'h1 << s.nvm_address_reg[1:0]);
  assign bus.prog_data = s.page_op ? bus.slots : {4{s.nvm_data_reg}};
  assign bus.prog_mode = s.program_mode_field;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    bus.load = 1'b0;
    bus.flush = 1'b0;
    bus.prog = 1'b0;
    if (mwe_pending) begin
      next_s.mwe_count = s.mwe_count - 3'h1;
    end
    if (s.memory_busy_flag && rc_tick) begin
      if (s.prog_count == 15'h0001) begin
        bus.prog = 1'b1;
        bus.flush = 1'b1;
        next_s.page_mode_bit = 1'b0;
        next_s.write_strobe = 1'b0;
        next_s.memory_busy_flag = 1'b0;
        next_s.prog_count = 15'h0000;
      end else begin
        next_s.prog_count = s.prog_count - 15'h0001;
      end
    end
    if (awvalid && awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    unique case (s.wst)
      WR_IDLE: begin
        if (wr_fire) begin
          next_s.aw_got = 1'b0;
          next_s.w_got = 1'b0;
          next_s.bresp = `RESP_OKAY;
          next_s.stall = 3'h0;
          if (s.aw_addr == `OFF_CTRL) begin
            if (s.w_strb[0]) begin
              if (!s.write_strobe) begin
                // mode and page bit frozen while strobing
                next_s.page_mode_bit = wd[`B_PAGE];
                next_s.program_mode_field = prog_mode_t'(wd[`B_MODE_HI:`B_MODE_LO]);
              end
              next_s.ready_irq_en = wd[`B_RIE];
              if (ws_fire) begin
                next_s.mwe_count = 3'h0;
                if (next_s.program_mode_field == MODE_FLUSH) begin
                  bus.flush = 1'b1;
                  next_s.page_mode_bit = 1'b0;
                end else begin
                  next_s.write_strobe = 1'b1;
                  next_s.memory_busy_flag = 1'b1;
                  next_s.prog_count = ticks_for(next_s.program_mode_field);
                  next_s.page_op = next_s.page_mode_bit;
                  next_s.stall = `STALL_WRITE;
                end
              end else if (wd[`B_MWE]) begin
                next_s.mwe_count = `MWE_WINDOW;
              end
              if (rd_fire) begin
                next_s.nvm_data_reg = bus.rd_data;
                next_s.stall = `STALL_READ;
              end
            end
          end else if (s.aw_addr == `OFF_ADDR) begin
            if (!s.memory_busy_flag) begin
              if (s.w_strb[0]) begin
                next_s.nvm_address_reg[7:0] = wd;
              end
              if (s.w_strb[1]) begin
                next_s.nvm_address_reg[8] = s.w_data[8];
              end
            end
          end else if (s.aw_addr == `OFF_DATA) begin
            if (data_fire) begin
              next_s.nvm_data_reg = wd;
              if (s.page_mode_bit) begin
                bus.load = 1'b1;
                next_s.stall = `STALL_LOAD;
              end
            end
          end else begin
            next_s.bresp = `RESP_SLVERR;
          end
          next_s.wst = (next_s.stall == 3'h0) ? WR_RESP : WR_STALL;
        end
      end
      WR_STALL: begin
        next_s.stall = s.stall - 3'h1;
        if (s.stall == 3'h1) begin
          next_s.wst = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          next_s.wst = WR_IDLE;
        end
      end
      default: next_s.wst = WR_IDLE;
    endcase
    if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `RESP_OKAY;
      if (araddr == `OFF_CTRL) begin
        next_s.rdata = {24'h000000, s.memory_busy_flag, s.page_mode_bit, s.program_mode_field,
                        s.ready_irq_en, mwe_pending, s.write_strobe, 1'b0};
      end else if (araddr == `OFF_ADDR) begin
        next_s.rdata = {23'h000000, s.nvm_address_reg};
      end else if (araddr == `OFF_DATA) begin
        next_s.rdata = {24'h000000, s.nvm_data_reg};
      end else begin
        next_s.rdata = 32'h00000000;
        next_s.rresp = `RESP_SLVERR;
      end
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign awready = (s.wst == WR_IDLE) && !s.aw_got;
  assign wready = (s.wst == WR_IDLE) && !s.w_got;
  assign bvalid = (s.wst == WR_RESP);
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  // the response is held back to model the processor halt
  assign cpu_halt = (s.wst == WR_STALL);
  assign ready_irq = !s.write_strobe && s.ready_irq_en;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_data: assert property (rd_fire |=> s.nvm_data_reg == $past(bus.rd_data))
    else $error("read byte not captured");
  a_read_stall: assert property (rd_fire |=> cpu_halt [*4] ##1 bvalid)
    else $error("read stall not four cycles");
  a_busy_lock: assert property (s.memory_busy_flag |=> $stable(s.nvm_address_reg))
    else $error("address changed while busy");
  a_busy_noread: assert property ((ctrl_wr && wd[`B_RS] && s.memory_busy_flag) |=> $stable(s.nvm_data_reg))
    else $error("read taken while busy");
  a_prog_start: assert property ($rose(s.memory_busy_flag) |-> s.prog_count == ticks_for(s.program_mode_field))
    else $error("program timer loaded wrong");
  a_prog_end: assert property (bus.prog |-> rc_tick && s.prog_count == 15'h0001)
    else $error("program ended early");
  a_page_load: assert property ((data_fire && s.page_mode_bit) |-> bus.load && bus.load_idx == s.nvm_address_reg[1:0])
    else $error("page byte not loaded");
  a_no_page: assert property ((data_fire && !s.page_mode_bit) |-> !bus.load)
    else $error("load without page mode");
  a_load_stall: assert property (bus.load |=> cpu_halt [*3] ##1 bvalid)
    else $error("load stall not three cycles");
  a_auto_clear: assert property (bus.prog |-> bus.flush ##1 (!s.page_mode_bit && !s.write_strobe && !s.memory_busy_flag))
    else $error("completion did not clear");
  a_flush_only: assert property ((bus.flush && !bus.prog) |-> !s.memory_busy_flag ##1 (!s.page_mode_bit && !s.memory_busy_flag))
    else $error("flush misbehaved");
  a_mwe_gate: assert property ((ctrl_wr && wd[`B_WS] && !mwe_pending && !s.write_strobe) |=> !s.write_strobe)
    else $error("strobe took effect without enable");
  a_mwe_expire: assert property ((s.mwe_count == 3'h4 && !wr_fire) ##1 (!wr_fire) [*3] |=> s.mwe_count == 3'h0)
    else $error("master enable did not expire");
  a_mode_hold: assert property (s.write_strobe |=> $stable(s.program_mode_field))
    else $error("mode changed while strobing");
  a_busy_span: assert property (s.write_strobe |-> s.memory_busy_flag && !ready_irq)
    else $error("busy flag dropped early");
endmodule : eeprom_page_access
`default_nettype wire

// file: rtl/eeprom_pkg.sv
`include "eeprom_map.svh"
`default_nettype none
package eeprom_pkg;
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'b00,
    MODE_ERASE = 2'b01,
    MODE_WRITE = 2'b10,
    MODE_FLUSH = 2'b11
  } prog_mode_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_STALL = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef struct packed {
    logic [3:0][7:0] slots;
    logic [3:0] filled;
  } buf_state_t;

  typedef struct packed {
    logic [`NVM_DEPTH-1:0][7:0] cells;
  } mem_state_t;

  typedef struct packed {
    wr_state_t wst;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [2:0] stall;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [8:0] nvm_address_reg;
    logic [7:0] nvm_data_reg;
    logic page_mode_bit;
    prog_mode_t program_mode_field;
    logic ready_irq_en;
    logic [2:0] mwe_count;
    logic write_strobe;
    logic memory_busy_flag;
    logic [14:0] prog_count;
    logic page_op;
  } ctrl_state_t;

  function automatic logic [7:0] programmed_byte(prog_mode_t m, logic [7:0] old, logic [7:0] val);
    unique case (m)
      MODE_ATOMIC: programmed_byte = val;
      MODE_ERASE: programmed_byte = `ERASED;
      MODE_WRITE: programmed_byte = old & val;
      MODE_FLUSH: programmed_byte = old;
    endcase
  endfunction : programmed_byte
endpackage : eeprom_pkg
`default_nettype wire

// file: rtl/nvm_array.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_array
  import eeprom_pkg::*;
(
  input wire logic aclk,
  nvm_if.mem bus
);
  // no reset: contents are meant to survive it
  mem_state_t s;
  mem_state_t next_s;

  always_comb begin
    next_s = s;
    if (bus.prog) begin
      for (int i = 0; i < 4; i++) begin
        if (bus.prog_mask[i]) begin
          next_s.cells[{bus.prog_page, 2'(i)}] =
            programmed_byte(bus.prog_mode, s.cells[{bus.prog_page, 2'(i)}], bus.prog_data[8*i +: 8]);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  assign bus.rd_data = s.cells[bus.rd_addr];
endmodule : nvm_array
`default_nettype wire

// file: rtl/nvm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nvm_if;
  import eeprom_pkg::*;
  logic load;
  logic [1:0] load_idx;
  logic [7:0] load_data;
  logic flush;
  logic [31:0] slots;
  logic [3:0] filled;
  logic [8:0] rd_addr;
  logic [7:0] rd_data;
  logic prog;
  logic [6:0] prog_page;
  logic [3:0] prog_mask;
  logic [31:0] prog_data;
  prog_mode_t prog_mode;
  modport pbuf(input load, load_idx, load_data, flush, output slots, filled);
  modport mem(input rd_addr, prog, prog_page, prog_mask, prog_data, prog_mode, output rd_data);
endinterface : nvm_if
`default_nettype wire

// file: rtl/page_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module page_buffer
  import eeprom_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  nvm_if.pbuf bus
);
  buf_state_t s;
  buf_state_t next_s;
  logic [7:0] merged;

  // repeated loads only clear bits, as the cell array does in write mode
  assign merged = s.slots[bus.load_idx] & bus.load_data;

  always_comb begin
    next_s = s;
    if (bus.flush) begin
      next_s.slots = {4{`ERASED}};
      next_s.filled = 4'h0;
    end else if (bus.load) begin
      next_s.slots[bus.load_idx] = merged;
      next_s.filled[bus.load_idx] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s.slots <= {4{`ERASED}};
      s.filled <= 4'h0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.slots = s.slots;
  assign bus.filled = s.filled;

  a_and_merge: assert property (@(posedge aclk) disable iff (!aresetn)
    (bus.load && !bus.flush) |=> s.slots[$past(bus.load_idx)] == $past(merged))
    else $error("page byte not merged by and");
  a_flush_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.flush |=> (s.filled == 4'h0) && (s.slots == {4{`ERASED}}))
    else $error("page buffer not cleared");
endmodule : page_buffer
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"
module tb_top;
  import eeprom_pkg::*;
  localparam int AT = 40;
  localparam int ST = 20;
  logic aclk, aresetn, awvalid, wvalid, arvalid, rc_tick;
  logic awready, wready, bvalid, arready, rvalid, cpu_halt, ready_irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd, keep, r;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [8:0] a, base;
  logic [7:0] d;
  logic [7:0] pv [0:3];
  int failures, checks_done, halt, ticks, t0;

  eeprom_page_access #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(1'h1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'h1), .rc_tick(rc_tick), .cpu_halt(cpu_halt),
    .ready_irq(ready_irq)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] exp_prog(input logic [1:0] m, input logic [7:0] o, input logic [7:0] v);
    case (m)
      2'h0: return v;
      2'h1: return 8'hFF;
      default: return o & v;
    endcase
  endfunction : exp_prog

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  // ----------------------------------------
  // bus cycles, entered just after an edge
  // ----------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] dv, input int eh);
    int n;
    logic aw, w, done;
    aw = 1'h1;
    w = 1'h1;
    done = 1'h0;
    halt = 0;
    awaddr <= ad;
    wdata <= dv;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 300 && !done; n++) begin
      @(posedge aclk);
      if (aw && awready === 1'h1) begin
        awvalid <= 1'h0;
        aw = 1'h0;
      end
      if (w && wready === 1'h1) begin
        wvalid <= 1'h0;
        w = 1'h0;
      end
      if (cpu_halt === 1'h1) halt++;
      if (bvalid === 1'h1) begin
        resp = bresp;
        done = 1'h1;
      end
    end
    if (!done) begin
      failures++;
      results();
    end
    chk_n(halt, eh);
  endtask : wr

  task automatic rdr(input logic [7:0] ad);
    int n;
    logic ar, done;
    ar = 1'h1;
    done = 1'h0;
    araddr <= ad;
    arvalid <= 1'h1;
    for (n = 0; n < 300 && !done; n++) begin
      @(posedge aclk);
      if (ar && arready === 1'h1) begin
        arvalid <= 1'h0;
        ar = 1'h0;
      end
      if (rvalid === 1'h1) begin
        rd = rdata;
        resp = rresp;
        done = 1'h1;
      end
    end
    if (!done) begin
      failures++;
      results();
    end
  endtask : rdr

  // reads a byte back through the read strobe
  task automatic rb(input logic [8:0] ad);
    wr(`OFF_ADDR, {23'h0, ad}, 0);
    wr(`OFF_CTRL, 32'h09, 4);
    rdr(`OFF_DATA);
  endtask : rb

  // master enable, strobe, refusals while busy, then poll
  task automatic prog(input logic [1:0] m, input logic pg);
    logic [7:0] c;
    int n;
    c = {1'h0, pg, m, 4'hA};
    wr(`OFF_CTRL, {24'h0, 1'h0, pg, m, 4'hC}, 0);
    t0 = ticks;
    wr(`OFF_CTRL, {24'h0, c}, 2);
    chk(ready_irq, 32'h0);
    rdr(`OFF_CTRL);
    chk(rd & 32'hFB, {24'h0, 8'h80 | c});
    rdr(`OFF_ADDR);
    keep = rd;
    wr(`OFF_ADDR, keep ^ 32'h3, 0);
    chk(resp, `RESP_OKAY);
    rdr(`OFF_ADDR);
    chk(rd, keep);
    wr(`OFF_CTRL, {24'h0, 1'h0, ~pg, 6'h3B}, 0);
    rdr(`OFF_CTRL);
    chk(rd & 32'hFB, {24'h0, 8'h80 | c});
    rdr(`OFF_CTRL);
    for (n = 0; n < 200 && rd[`B_WS] === 1'h1; n++) rdr(`OFF_CTRL);
    if (rd[`B_WS] !== 1'h0) begin
      failures++;
      results();
    end
    chk(rd & 32'hFB, {24'h0, 2'h0, m, 4'h8});
    chk(ready_irq, 32'h1);
    n = ticks - t0 - ((m == 2'h0) ? AT : ST);
    chk_n(n >= 0 && n <= 5, 1);
  endtask : prog

  // ----------------------------------------
  // clock, oscillator ticks, stimulus
  // ----------------------------------------
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_tick <= 1'h0;
      ticks <= 0;
    end else begin
      rc_tick <= ~rc_tick;
      if (rc_tick) ticks <= ticks + 1;
    end
  end

  initial begin
    aresetn = 1'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    arvalid = 1'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    seed = 32'h15;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(`OFF_CTRL);
    chk(rd, 32'h0);
    chk(ready_irq, 32'h0);
    wr(8'h0C, rnd(), 0);
    chk(resp, `RESP_SLVERR);
    rdr(8'h10);
    chk(resp, `RESP_SLVERR);
    r = rnd();
    a = r[8:0];
    for (int m = 0; m < 3; m++) begin
      r = rnd();
      d = r[7:0];
      wr(`OFF_ADDR, {23'h0, a}, 0);
      wr(`OFF_DATA, {24'h0, d}, 0);
      prog(m[1:0], 1'h0);
      pv[0] = exp_prog(m[1:0], pv[0], d);
      rb(a);
      chk(rd, {24'h0, pv[0]});
    end
    wr(`OFF_CTRL, 32'h0C, 0);
    repeat (6) @(posedge aclk);
    wr(`OFF_CTRL, 32'h0A, 0);
    rdr(`OFF_CTRL);
    chk(rd & 32'h82, 32'h0);
    r = rnd();
    base = {r[6:0], 2'h0};
    wr(`OFF_CTRL, 32'h48, 0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      pv[i] = (i == 0) ? 8'hAA : r[7:0];
      wr(`OFF_ADDR, {23'h0, base[8:2], i[1:0]}, 0);
      wr(`OFF_DATA, {24'h0, pv[i]}, 3);
    end
    wr(`OFF_ADDR, {23'h0, base}, 0);
    wr(`OFF_DATA, 32'h55, 3);
    pv[0] = 8'h00;
    prog(2'h0, 1'h1);
    for (int i = 0; i < 4; i++) begin
      rb({base[8:2], i[1:0]});
      chk(rd, {24'h0, pv[i]});
    end
    wr(`OFF_CTRL, 32'h48, 0);
    wr(`OFF_ADDR, {23'h0, base[8:2], 2'h2}, 0);
    wr(`OFF_DATA, 32'h00, 3);
    wr(`OFF_CTRL, 32'h7C, 0);
    wr(`OFF_CTRL, 32'h7A, 0);
    rdr(`OFF_CTRL);
    chk(rd & 32'hFB, 32'h38);
    wr(`OFF_CTRL, 32'h48, 0);
    wr(`OFF_ADDR, {23'h0, base}, 0);
    wr(`OFF_DATA, 32'hC3, 3);
    prog(2'h0, 1'h1);
    rb(base);
    chk(rd, 32'hC3);
    rb({base[8:2], 2'h2});
    chk(rd, {24'h0, pv[2]});
    results();
  end
endmodule : tb_top
`default_nettype wire
